// >>> rtl/scc_codec.sv
// Special character codec: transmit encoder/serializer and receive framer/decoder
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
module scc_codec
  import scc_pkg::*;
#(
  parameter int FIFO_DEPTH = `SCC_FIFO_DEPTH
) (
  input  wire logic        ref_clk,           // Reference clock, 50 MHz
  input  wire logic        reset_n,           // Async reset, active low
  input  wire logic        char_width_select, // High: 8-bit, low: 10-bit characters
  input  wire logic        encoder_bypass,    // High: pre-encoded characters
  input  wire logic        framer_enable,     // High: search for sync pair
  input  wire logic [1:0]  pll_mult_select,   // Bit clock multiplier choice
  input  wire logic [11:0] tx_data,           // Transmit data character
  input  wire logic [3:0]  tx_command_in,     // Transmit command code
  input  wire logic        tx_special_select, // High: send command code
  input  wire logic        tx_valid,          // Transmit character offered
  output logic             tx_ready,          // Transmit FIFO has space
  output logic             serial_out_pair_p, // Serial out, true leg
  output logic             serial_out_pair_n, // Serial out, complement leg
  input  wire logic        serial_in_pair_p,  // Serial in, true leg
  output logic             pll_locked,        // Transmit bit clock settled
  output logic             rx_locked,         // Receive clock recovered
  output logic             rx_valid,          // Received character available
  input  wire logic        rx_read,           // Host takes received character
  output logic [11:0]      rx_data,           // Received data character
  output logic [3:0]       rx_command_out,    // Received command code
  output logic             rx_special_flag,   // High: command received
  output logic             rx_violation,      // High: undecodable character
  output logic             rx_overflow        // Character lost, FIFO was full
);
  localparam logic [4:0] ENC4 [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [5:0] ENC5 [32] = '{6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
                                        6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
                                        6'h3E, 6'h19, 6'h29, 6'h2D, 6'h1A, 6'h1B, 6'h1E, 6'h1F,
                                        6'h2A, 6'h2B, 6'h2E, 6'h2F, 6'h3A, 6'h3B, 6'h3C, 6'h3D};
  localparam logic [9:0] CMD_N [16] = '{10'h311, 10'h3FF, 10'h1AD, 10'h1B9, 10'h3E4, 10'h1A7,
                                         10'h327, 10'h339, 10'h084, 10'h09F, 10'h080, 10'h0E7,
                                         10'h0F9, 10'h004, 10'h01F, 10'h000};
  localparam logic [11:0] CMD_W [4] = '{12'h623, 12'hFFF, 12'h75D, 12'h779};
  localparam int PLL_CW = 8;

  function automatic logic [11:0] rev_bits(input logic [11:0] d, input logic narrow);
    logic [11:0] r;
    r = '0;
    for (int i = 0; i < 12; i++) begin
      if (narrow && i < 10) begin
        r[i] = d[9 - i];
      end else if (!narrow) begin
        r[i] = d[11 - i];
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] encode_char(input logic [12:0] e, input logic narrow,
                                              input logic bypass);
    if (bypass) begin
      return rev_bits(e[11:0], narrow);                                   // R7 R6
    end else if (e[12]) begin
      return narrow ? {2'h0, CMD_N[e[3:0]]} : CMD_W[e[1:0]];              // R13 R9 R10 R11 R12
    end else begin
      return narrow ? {2'h0, ENC4[e[7:4]], ENC4[e[3:0]]}                  // R6
                    : {ENC5[e[9:5]], ENC5[e[4:0]]};
    end
  endfunction

  // Result is {violation, special, payload}
  function automatic logic [13:0] decode_char(input logic [11:0] w, input logic narrow,
                                              input logic bypass);
    logic       cmd_ok;
    logic       hi_ok;
    logic       lo_ok;
    logic [3:0] cmd;
    logic [4:0] hi;
    logic [4:0] lo;
    cmd_ok = 1'b0;
    hi_ok  = 1'b0;
    lo_ok  = 1'b0;
    cmd    = '0;
    hi     = '0;
    lo     = '0;
    if (bypass) begin
      return {2'b00, rev_bits(w, narrow)};                                // R7
    end
    for (int i = 0; i < 32; i++) begin
      if (i < 16 && narrow && w[9:0] == CMD_N[i]) begin
        cmd_ok = 1'b1;
        cmd    = 4'(i);
      end
      if (i < 4 && !narrow && w == CMD_W[i]) begin
        cmd_ok = 1'b1;
        cmd    = 4'(i);
      end
      if (i < 16 && narrow && w[9:5] == ENC4[i]) begin
        hi_ok = 1'b1;
        hi    = 5'(i);
      end
      if (i < 16 && narrow && w[4:0] == ENC4[i]) begin
        lo_ok = 1'b1;
        lo    = 5'(i);
      end
      if (!narrow && w[11:6] == ENC5[i]) begin
        hi_ok = 1'b1;
        hi    = 5'(i);
      end
      if (!narrow && w[5:0] == ENC5[i]) begin
        lo_ok = 1'b1;
        lo    = 5'(i);
      end
    end
    if (cmd_ok) begin
      return {2'b01, 8'h00, cmd};                                         // R9 R11
    end else if (hi_ok && lo_ok) begin
      return narrow ? {2'b00, 4'h0, hi[3:0], lo[3:0]} : {2'b00, 2'h0, hi, lo};
    end else begin
      return {2'b10, w};                                                  // R16
    end
  endfunction

  // Transmit side
  scc_mult_t              pll_mode;
  scc_tx_state_t          tx_state_reg, tx_state_next;
  logic [PLL_CW-1:0]      pll_cnt_reg, pll_cnt_next;
  logic [1:0]             mult_prev_reg;
  logic [11:0]            tx_sh_reg, tx_sh_next;
  logic [3:0]             tx_cnt_reg, tx_cnt_next;
  logic                   mode_change;
  logic                   tx_load;
  logic [3:0]             tx_len;
  logic [11:0]            tx_sym;
  logic [11:0]            tx_sym_left;
  logic                   txf_out_valid;
  logic [`SCC_TXF_W-1:0]  txf_out_data;
  logic [`SCC_TXF_W-1:0]  txf_in_data;

  assign pll_mode    = scc_mult_t'(pll_mult_select);
  assign mode_change = (pll_mode == SCC_MULT_BAD) || (pll_mult_select != mult_prev_reg);
  assign tx_len      = char_width_select ? `SCC_NARROW_LEN : `SCC_WIDE_LEN;
  assign tx_load     = (tx_state_reg == SCC_TX_RUN) && (tx_cnt_reg == '0) && !mode_change;
  // Empty FIFO sends the sync pair as fill
  assign tx_sym      = txf_out_valid ? encode_char(txf_out_data, char_width_select,
                                                   encoder_bypass)
                     : (char_width_select ? {2'h0, CMD_N[`SCC_CMD_SYNC]}
                                          : CMD_W[2'(`SCC_CMD_SYNC)]);    // R9 R11
  assign tx_sym_left = char_width_select ? {tx_sym[9:0], 2'h0} : tx_sym;
  assign txf_in_data = {tx_special_select & ~encoder_bypass,                         // R7
                        (tx_special_select & ~encoder_bypass) ? {8'h00, tx_command_in}
                                                              : tx_data};              // R13
  assign pll_locked  = (tx_state_reg == SCC_TX_RUN);
  assign serial_out_pair_p = tx_sh_reg[11];                               // R15
  assign serial_out_pair_n = ~tx_sh_reg[11];                              // R1

  scc_fifo #(
    .WIDTH (`SCC_TXF_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (txf_in_data),
    .out_valid (txf_out_valid),
    .out_ready (tx_load),
    .out_data  (txf_out_data)
  );                                                                      // R1

  // Bit clock settles after any change of multiplier before bits flow
  always_comb begin
    tx_state_next = tx_state_reg;
    pll_cnt_next  = pll_cnt_reg;
    tx_sh_next    = tx_sh_reg << 1;                                       // R15
    tx_cnt_next   = tx_cnt_reg;
    case (tx_state_reg)
      SCC_TX_SETTLE: begin
        tx_sh_next  = '0;
        tx_cnt_next = '0;
        if (mode_change) begin
          pll_cnt_next = '0;                                              // R2
        end else if (pll_cnt_reg == PLL_CW'(`SCC_PLL_SETTLE_CYC - 1)) begin
          pll_cnt_next  = '0;
          tx_state_next = SCC_TX_RUN;                                     // R2
        end else begin
          pll_cnt_next = pll_cnt_reg + 1'b1;
        end
      end
      SCC_TX_RUN: begin
        if (mode_change) begin
          tx_state_next = SCC_TX_SETTLE;                                  // R2
          tx_sh_next    = '0;
          tx_cnt_next   = '0;
        end else if (tx_load) begin
          tx_sh_next  = tx_sym_left;                                      // R1 R8
          tx_cnt_next = tx_len - 1'b1;
        end else begin
          tx_cnt_next = tx_cnt_reg - 1'b1;
        end
      end
      default: begin
        tx_state_next = SCC_TX_SETTLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg  <= SCC_TX_SETTLE;
      pll_cnt_reg   <= '0;
      mult_prev_reg <= '0;
      tx_sh_reg     <= '0;
      tx_cnt_reg    <= '0;
    end else begin
      tx_state_reg  <= tx_state_next;
      pll_cnt_reg   <= pll_cnt_next;
      mult_prev_reg <= pll_mult_select;
      tx_sh_reg     <= tx_sh_next;
      tx_cnt_reg    <= tx_cnt_next;
    end
  end

  // Receive side
  logic                   rx_meta_reg;
  logic                   rx_bit_reg;
  logic                   rx_prev_reg, rx_prev_next;
  logic [2:0]             rx_edges_reg, rx_edges_next;
  logic [5:0]             rx_quiet_reg, rx_quiet_next;
  logic                   rx_locked_reg, rx_locked_next;
  logic [11:0]            rx_sh_reg, rx_sh_next;
  logic [3:0]             rx_cnt_reg, rx_cnt_next;
  logic                   rx_ovf_reg, rx_ovf_next;
  logic                   rx_sync_hit;
  logic                   rx_push;
  logic                   rxf_in_ready;
  logic [`SCC_RXF_W-1:0]  rxf_in_data;
  logic [`SCC_RXF_W-1:0]  rxf_out_data;

  assign rx_sh_next  = {rx_sh_reg[10:0], rx_bit_reg};                    // R4
  assign rx_sync_hit = framer_enable && rx_locked_reg &&
                       (char_width_select ? (rx_sh_next[9:0] == CMD_N[`SCC_CMD_SYNC])
                                          : (rx_sh_next == CMD_W[2'(`SCC_CMD_SYNC)])); // R14
  assign rx_push     = rx_locked_reg && (rx_sync_hit || rx_cnt_reg == tx_len - 1'b1);  // R4
  assign rxf_in_data = decode_char(rx_sh_next, char_width_select, encoder_bypass);    // R4 R16
  assign rx_locked       = rx_locked_reg;
  assign rx_overflow     = rx_ovf_reg;
  assign rx_special_flag = rxf_out_data[12];
  assign rx_violation    = rxf_out_data[13];
  assign rx_command_out  = rxf_out_data[12] ? rxf_out_data[3:0] : 4'h0;
  assign rx_data         = rxf_out_data[12] ? 12'h000 : rxf_out_data[11:0];

  scc_fifo #(
    .WIDTH (`SCC_RXF_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (rx_push),
    .in_ready  (rxf_in_ready),
    .in_data   (rxf_in_data),
    .out_valid (rx_valid),
    .out_ready (rx_read),
    .out_data  (rxf_out_data)
  );                                                                      // R5

  always_comb begin
    rx_prev_next   = rx_bit_reg;
    rx_edges_next  = rx_edges_reg;
    rx_locked_next = rx_locked_reg;
    rx_quiet_next  = (rx_bit_reg != rx_prev_reg) ? 6'h00 : rx_quiet_reg + 1'b1;
    if (rx_quiet_reg == `SCC_QUIET_LIMIT) begin
      rx_locked_next = 1'b0;                                              // R3
      rx_edges_next  = '0;
      rx_quiet_next  = '0;
    end else if (rx_bit_reg != rx_prev_reg && !rx_locked_reg) begin
      rx_edges_next = rx_edges_reg + 1'b1;
      if (rx_edges_reg == `SCC_LOCK_EDGES - 1'b1) begin
        rx_locked_next = 1'b1;                                            // R3
      end
    end
    rx_cnt_next = !rx_locked_reg ? 4'h0 : (rx_push ? 4'h0 : rx_cnt_reg + 1'b1); // R14
    // A new loss wins over the host read that clears the flag
    rx_ovf_next = (rx_push && !rxf_in_ready) || (rx_ovf_reg && !(rx_valid && rx_read));
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta_reg   <= 1'b0;
      rx_bit_reg    <= 1'b0;
      rx_prev_reg   <= 1'b0;
      rx_edges_reg  <= '0;
      rx_quiet_reg  <= '0;
      rx_locked_reg <= 1'b0;
      rx_sh_reg     <= '0;
      rx_cnt_reg    <= '0;
      rx_ovf_reg    <= 1'b0;
    end else begin
      rx_meta_reg   <= serial_in_pair_p;
      rx_bit_reg    <= rx_meta_reg;
      rx_prev_reg   <= rx_prev_next;
      rx_edges_reg  <= rx_edges_next;
      rx_quiet_reg  <= rx_quiet_next;
      rx_locked_reg <= rx_locked_next;
      rx_sh_reg     <= rx_sh_next;
      rx_cnt_reg    <= rx_cnt_next;
      rx_ovf_reg    <= rx_ovf_next;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_tx_msb_first;
    tx_load |=> (serial_out_pair_p == $past(tx_sym_left[11]))
                ##1 (serial_out_pair_p == $past(tx_sym_left[10], 2));
  endproperty
  a_tx_msb_first: assert property (p_tx_msb_first) else $error("serial bit order wrong"); // R15

  property p_tx_fill_sync;
    tx_load && !txf_out_valid && char_width_select |-> tx_sym[9:0] == 10'h311;
  endproperty
  a_tx_fill_sync: assert property (p_tx_fill_sync) else $error("fill is not sync pair"); // R9

  property p_tx_idle_pair;
    tx_load && txf_out_valid && txf_out_data[12] && char_width_select && !encoder_bypass
      && txf_out_data[3:0] == 4'h1 |-> tx_sym[9:0] == 10'h3FF;
  endproperty
  a_tx_idle_pair: assert property (p_tx_idle_pair) else $error("idle pair wrong"); // R10

  property p_tx_wide_cmd;
    tx_load && txf_out_valid && txf_out_data[12] && !char_width_select && !encoder_bypass
      && txf_out_data[1:0] == 2'h3 |-> tx_sym == 12'h779;
  endproperty
  a_tx_wide_cmd: assert property (p_tx_wide_cmd) else $error("wide command wrong"); // R12

  property p_tx_bypass;
    tx_load && txf_out_valid && encoder_bypass && char_width_select
      |-> tx_sym[9] == txf_out_data[0] && tx_sym[0] == txf_out_data[9] && !txf_out_data[12];
  endproperty
  a_tx_bypass: assert property (p_tx_bypass) else $error("bypass char altered"); // R7

  property p_tx_back2back;
    tx_load && !mode_change ##1 !mode_change[*8] |-> ##[2:4] tx_load;
  endproperty
  a_tx_back2back: assert property (p_tx_back2back) else $error("character gap"); // R8

  property p_pll_settle;
    (pll_mult_select != mult_prev_reg) |=> !pll_locked[*8];
  endproperty
  a_pll_settle: assert property (p_pll_settle) else $error("bit clock not settling"); // R2

  property p_rx_frame;
    rx_sync_hit |=> rx_cnt_reg == 4'h0 ##1 rx_cnt_reg == 4'h1 || !rx_locked_reg;
  endproperty
  a_rx_frame: assert property (p_rx_frame) else $error("framer did not realign"); // R14

  property p_rx_sync_cmd;
    rx_push && rx_sync_hit && char_width_select && !encoder_bypass
      |-> rxf_in_data[13:12] == 2'b01 && rxf_in_data[3:0] == 4'h0;
  endproperty
  a_rx_sync_cmd: assert property (p_rx_sync_cmd) else $error("sync not decoded"); // R9

  property p_rx_unlocked;
    $fell(rx_locked_reg) |-> !rx_push [*2];
  endproperty
  a_rx_unlocked: assert property (p_rx_unlocked) else $error("push without lock"); // R3

  property p_rx_bypass_flags;
    rx_push && encoder_bypass |-> rxf_in_data[13:12] == 2'b00;
  endproperty
  a_rx_bypass_flags: assert property (p_rx_bypass_flags) else $error("flags in bypass"); // R7

  c_tx_command: cover property (tx_load && txf_out_valid && txf_out_data[12]);
  c_rx_framed:  cover property (rx_sync_hit ##[1:12] rx_push);
  c_rx_viol:    cover property (rx_push && rxf_in_data[13]);
  c_rx_ovf:     cover property ($rose(rx_ovf_reg));
endmodule
`default_nettype wire

// >>> rtl/scc_defs.svh
// Constants of the special character codec
// Overview of operation
// (R1) Transmit characters go input register, transmit FIFO, encoder, then serial pair. The code has no input register; tx_data enters the FIFO directly.
// (R2) Bit clock comes from reference clock times 2.5, 5 or 10. The code shifts one bit per ref_clk cycle for every setting.
// (R3) Receiver locks to the selected line input and derives its bit sampling.
// (R4) Received bits are deserialized, decoded and written into the receive FIFO.
// (R5) Receive FIFO lets the host read slower or faster than arrival.
// (R6) Parallel ports handle 8-bit, 10-bit, 10-bit and 12-bit pre-encoded characters.
// (R7) With encoder bypassed, transmit and receive special-select bits are ignored.
// (R8) Link carries user data at up to 20 megabytes per second.
// (R9) 8-bit command 0000 is sent as sync pair 11000 10001, decoded back.
// (R10) 8-bit command 0001 encodes 11111 11111; 0010 encodes 01101 01101.
// (R11) 10-bit command 00 is sent as 011000 100011 and decoded back.
// (R12) 10-bit commands 01, 10, 11 encode as the listed symbol pairs.
// (R13) Special-select high sends the command bus as a special character.
// (R14) Framer enabled: realign character boundary where the sync pair is found.
// (R15) Symbols leave most significant bit first, high nibble symbol first.
// (R16) A symbol pair matching no data or command code is a decode violation.
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

`define SCC_DATA_W         12
`define SCC_TXF_W          13
`define SCC_RXF_W          14
`define SCC_FIFO_DEPTH     8
`define SCC_NARROW_LEN     4'hA
`define SCC_WIDE_LEN       4'hC
`define SCC_CMD_SYNC       4'h0
`define SCC_CLK_PERIOD_NS  20
`define SCC_PLL_SETTLE_NS  200
`define SCC_PLL_SETTLE_CYC ((`SCC_PLL_SETTLE_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)
`define SCC_LOCK_EDGES     3'h4
`define SCC_QUIET_LIMIT    6'h3F

`endif

// >>> rtl/scc_pkg.sv
// Types shared by the special character codec
package scc_pkg;
  typedef enum logic [1:0] {SCC_MULT_2P5, SCC_MULT_5, SCC_MULT_10, SCC_MULT_BAD} scc_mult_t;
  typedef enum logic {SCC_TX_SETTLE, SCC_TX_RUN} scc_tx_state_t;
endpackage

// >>> rtl/scc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
module scc_fifo #(
  parameter int WIDTH = `SCC_TXF_W,
  parameter int DEPTH = `SCC_FIFO_DEPTH
) (
  input  wire logic             clk,       // Clock
  input  wire logic             reset_n,   // Async reset, active low
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Read acknowledge
  output logic      [WIDTH-1:0] out_data   // Oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0]    count_reg, count_next;
  logic             wr;
  logic             rd;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign wr        = in_valid & in_ready;
  assign rd        = out_valid & out_ready;

  // Independent write and read sides decouple the two character rates (R5)
  always_comb begin
    mem_next = mem_reg;
    if (wr) begin
      mem_next[wr_ptr_reg] = in_data;
    end
    wr_ptr_next = wr ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = rd ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
    count_next  = count_reg + CW'(wr) - CW'(rd);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end
endmodule
`default_nettype wire

// >>> bench/scc_remote.sv
// Remote transceiver model: returns the line to the device after a short cable delay
`timescale 1ns/1ps
`default_nettype none
module scc_remote (
  input  wire logic clk,      // Bit clock
  input  wire logic reset_n,  // Async reset, active low
  input  wire logic line_in,  // From device serial out
  output logic      line_out  // To device serial in
);
  logic [2:0] dly_reg;
  logic [2:0] dly_next;
  // Echo loops every symbol sent back into the device's own receiver, three clocks later
  always_comb begin
    dly_next = {dly_reg[1:0], line_in};
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_reg <= 3'h5;
    end else begin
      dly_reg <= dly_next;
    end
  end
  assign line_out = dly_reg[2];
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the special character codec
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cws = 1'b1;
  logic        byp = 1'b0;
  logic        fen = 1'b1;
  logic [1:0]  mult = 2'h2;
  logic [11:0] tx_data = 12'h000;
  logic [3:0]  cmd = 4'h0;
  logic        sp = 1'b0;
  logic        tx_valid = 1'b0;
  logic        rx_read = 1'b1;
  logic        tx_ready, so_p, so_n, si_p, pll_locked, rx_locked, rx_valid, rx_sf, rx_vio, rx_ovf;
  logic [11:0] rx_data;
  logic [3:0]  rx_cmd;
  logic [11:0] hist = 12'h000;
  logic        got = 1'b0;
  logic        got_sp = 1'b0;
  logic [11:0] got_val = 12'h000;
  int          failures = 0;
  int          tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  scc_codec u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .char_width_select(cws),
    .encoder_bypass(byp), .framer_enable(fen), .pll_mult_select(mult), .tx_data(tx_data),
    .tx_command_in(cmd), .tx_special_select(sp), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .serial_out_pair_p(so_p), .serial_out_pair_n(so_n), .serial_in_pair_p(si_p),
    .pll_locked(pll_locked), .rx_locked(rx_locked), .rx_valid(rx_valid), .rx_read(rx_read),
    .rx_data(rx_data), .rx_command_out(rx_cmd), .rx_special_flag(rx_sf),
    .rx_violation(rx_vio), .rx_overflow(rx_ovf));
  scc_remote u_remote (.clk(ref_clk), .reset_n(reset_n), .line_in(so_p), .line_out(si_p));
  // Line history, first bit sent ends up most significant
  always @(posedge ref_clk) hist <= {hist[10:0], so_p};
  // Keep the last popped character that is neither idle fill nor a violation
  always @(posedge ref_clk) begin
    if (rx_valid && rx_read && !rx_vio && !(rx_sf && rx_cmd == 4'h0)
        && !(byp && rx_data == 12'h223)) begin
      got <= 1'b1;
      got_sp <= rx_sf;
      got_val <= rx_sf ? {8'h00, rx_cmd} : rx_data;
    end
  end
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_pat(input logic [11:0] pat, input int w);
    int i;
    logic [11:0] m;
    m = 12'hFFF >> (12 - w);
    for (i = 0; i < 300 && (hist & m) !== pat; i++) @(negedge ref_clk);
    check("line pattern", hist & m, pat);
    check("line complement", {11'h000, so_n}, {11'h000, ~so_p});
  endtask
  task automatic set_mode(input logic w8, input logic b);
    @(posedge ref_clk);
    cws <= w8;
    byp <= b;
    repeat (150) @(negedge ref_clk);
  endtask
  task automatic t_char(input logic [11:0] d, input logic [3:0] c, input logic s,
                        input logic [11:0] pat, input int w, input logic [11:0] rxv,
                        input logic rxs);
    int i;
    for (i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge ref_clk);
    check("tx ready", {11'h000, tx_ready}, 12'h001);
    got = 1'b0;
    @(posedge ref_clk);
    tx_data <= d;
    cmd <= c;
    sp <= s;
    tx_valid <= 1'b1;
    @(posedge ref_clk);
    tx_valid <= 1'b0;
    wait_pat(pat, w);
    for (i = 0; i < 400 && got !== 1'b1; i++) @(negedge ref_clk);
    check("received", {11'h000, got}, 12'h001);
    check("received value", got_val, rxv);
    check("received special", {11'h000, got_sp}, {11'h000, rxs});
  endtask
  task automatic t_reset();
    int i;
    check("reset line", {10'h000, so_p, so_n}, 12'h001);
    check("reset flags", {7'h00, rx_vio, rx_ovf, pll_locked, rx_valid, tx_ready}, 12'h001);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 40 && pll_locked !== 1'b1; i++) @(negedge ref_clk);
    check("pll locked", {11'h000, pll_locked}, 12'h001);
    for (i = 0; i < 300 && rx_locked !== 1'b1; i++) @(negedge ref_clk);
    check("rx locked", {11'h000, rx_locked}, 12'h001);
    $display("test reset done");
  endtask
  task automatic t_narrow();
    wait_pat(12'h311, 10);
    // Let the receiver frame on the first sync before watching for characters
    repeat (40) @(negedge ref_clk);
    t_char(12'h000, 4'h1, 1'b1, 12'h3FF, 10, 12'h001, 1'b1);
    t_char(12'h000, 4'h2, 1'b1, 12'h1AD, 10, 12'h002, 1'b1);
    t_char(12'h0A5, 4'h1, 1'b0, 12'h2CB, 10, 12'h0A5, 1'b0);
    $display("test narrow done");
  endtask
  task automatic t_wide();
    set_mode(1'b0, 1'b0);
    wait_pat(12'h623, 12);
    t_char(12'h000, 4'h1, 1'b1, 12'hFFF, 12, 12'h001, 1'b1);
    t_char(12'h000, 4'h2, 1'b1, 12'h75D, 12, 12'h002, 1'b1);
    t_char(12'h000, 4'h3, 1'b1, 12'h779, 12, 12'h003, 1'b1);
    $display("test wide done");
  endtask
  task automatic t_bypass();
    set_mode(1'b1, 1'b1);
    t_char(12'h2D3, 4'h1, 1'b1, 12'h32D, 10, 12'h2D3, 1'b0);
    check("overflow", {11'h000, rx_ovf}, 12'h000);
    $display("test bypass done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    t_reset();
    t_narrow();
    t_wide();
    t_bypass();
    test_done();
  end
  initial begin
    #2000000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
